/* logic/sfb_pkg.sv */
// Constants, encodings and types of the status flag and bit operation slice
package sfb_pkg;

  // ==========================================================================
  // Data address and register map
  localparam logic [4:0]  STATUS_FILE_ADDR = 5'h03;
  localparam logic [7:0]  REG_STATUS_IDX   = {3'h0, STATUS_FILE_ADDR};
  localparam logic [7:0]  REG_ACC_IDX      = 8'h04;
  localparam logic [7:0]  REG_STATE_IDX    = 8'h05;
  localparam logic [7:0]  ADDR_STATUS      = {REG_STATUS_IDX[5:0], 2'b00};
  localparam logic [7:0]  ADDR_ACC         = {REG_ACC_IDX[5:0], 2'b00};
  localparam logic [7:0]  ADDR_STATE       = {REG_STATE_IDX[5:0], 2'b00};

  // ==========================================================================
  // Status field positions and reset value
  localparam int          BIT_C            = 0;
  localparam int          BIT_DC           = 1;
  localparam int          BIT_Z            = 2;
  localparam int          BIT_PD           = 3;
  localparam int          BIT_TO           = 4;
  localparam int          BIT_PAGE_LO      = 5;
  localparam int          BIT_PAGE_HI      = 6;
  localparam int          BIT_SPARE        = 7;
  localparam logic [7:0]  STATUS_RESET     = 8'h18;

  // ==========================================================================
  // Program page window: 512 words per page
  localparam int          PAGE_SHIFT       = 9;
  localparam int          PC_W             = 11;
  localparam logic [8:0]  PAGE_OFFSET_ZERO = 9'h000;

  // ==========================================================================
  // Instruction encodings (12-bit words)
  localparam logic [5:0]  OP_ADD           = 6'h07;
  localparam logic [5:0]  OP_SUB           = 6'h02;
  localparam logic [5:0]  OP_SWAP          = 6'h0E;
  localparam logic [5:0]  OP_ROT_RIGHT     = 6'h0C;
  localparam logic [5:0]  OP_ROT_LEFT      = 6'h0D;
  localparam logic [6:0]  OP_CLEAR         = 7'h03;
  localparam logic [6:0]  OP_ACC_STORE     = 7'h01;
  localparam logic [3:0]  OP_BIT_CLEAR     = 4'h4;
  localparam logic [3:0]  OP_BIT_SET       = 4'h5;
  localparam logic [3:0]  OP_TEST_CLEAR    = 4'h6;
  localparam logic [3:0]  OP_TEST_SET      = 4'h7;

  // ==========================================================================
  // Instruction cycle phases, one-hot
  typedef enum logic [3:0] {
    PH_FETCH = 4'h1,
    PH_READ  = 4'h2,
    PH_EXEC  = 4'h4,
    PH_WRITE = 4'h8
  } sfb_phase_t;

endpackage

/* logic/sfb_file_mem.sv */
// General purpose file registers, 32 bytes, registered read port
module sfb_file_mem (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] rd_addr,
  output logic      [7:0] rd_data,
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_addr,
  input  wire logic [7:0] wr_data
);

  // ==========================================================================
  // Storage
  logic [7:0] mem [32];

  // Array is left without reset, as software must initialise file registers
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

/* logic/sfb_core.sv */
// Status register, flag logic and bit / subtract / swap datapath with APB access
//
// Our own choice: register access over APB.
module sfb_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] instr,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  output logic             instr_done,
  output logic             instr_discarded,
  output logic             skip_pending,
  input  wire logic        wdt_kick,
  input  wire logic        sleep_exec,
  input  wire logic        wdt_timeout,
  output logic      [10:0] page_base
);

  // ==========================================================================
  // State
  typedef struct packed {
    sfb_pkg::sfb_phase_t phase;
    logic [11:0]         ir;
    logic                squash;
    logic                skipped;
    logic                skip_pend;
    logic [7:0]          opnd;
    logic [7:0]          w;
    logic [7:0]          status;
    logic                done;
    logic                discarded;
    logic [31:0]         prdata;
  } sfb_state_t;

  localparam sfb_state_t ST_RESET = '{
    phase:     sfb_pkg::PH_FETCH,
    ir:        12'h000,
    squash:    1'b1,
    skipped:   1'b0,
    skip_pend: 1'b0,
    opnd:      8'h00,
    w:         8'h00,
    status:    sfb_pkg::STATUS_RESET,
    done:      1'b0,
    discarded: 1'b0,
    prdata:    32'h0000_0000
  };

  sfb_state_t  st;
  sfb_state_t  next_st;

  logic [4:0]  f_addr;
  logic        dest_f;
  logic [2:0]  bit_idx;
  logic [7:0]  bit_mask;
  logic        live;
  logic        op_add;
  logic        op_sub;
  logic        op_swap;
  logic        op_rrf;
  logic        op_rlf;
  logic        op_clr;
  logic        op_store;
  logic        op_bclr;
  logic        op_bset;
  logic        op_tclr;
  logic        op_tset;
  logic        to_status;
  logic [8:0]  sum_add;
  logic [8:0]  sum_sub;
  logic [4:0]  nib_add;
  logic [4:0]  nib_sub;
  logic [7:0]  res;
  logic [2:0]  upd;
  logic        c_new;
  logic        dc_new;
  logic        writes;
  logic        to_file;
  logic        to_w;
  logic        mem_we;
  logic [4:0]  mem_raddr;
  logic [7:0]  mem_rdata;
  logic        apb_wr;
  logic        apb_hit;
  logic [31:0] rd_mux;

  // ==========================================================================
  // File registers
  sfb_file_mem u_mem (
    .clk     (pclk),
    .rst_n   (presetn),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata),
    .wr_en   (mem_we),
    .wr_addr (f_addr),
    .wr_data (res)
  );

  // ==========================================================================
  // Decode
  assign f_addr    = st.ir[4:0];
  assign dest_f    = st.ir[5];
  assign bit_idx   = st.ir[7:5];
  assign bit_mask  = 8'(8'h01 << bit_idx);
  assign live      = !st.squash;
  assign op_add    = live && (st.ir[11:6] == sfb_pkg::OP_ADD);
  assign op_sub    = live && (st.ir[11:6] == sfb_pkg::OP_SUB);
  assign op_swap   = live && (st.ir[11:6] == sfb_pkg::OP_SWAP);
  assign op_rrf    = live && (st.ir[11:6] == sfb_pkg::OP_ROT_RIGHT);
  assign op_rlf    = live && (st.ir[11:6] == sfb_pkg::OP_ROT_LEFT);
  assign op_clr    = live && (st.ir[11:5] == sfb_pkg::OP_CLEAR);
  assign op_store  = live && (st.ir[11:5] == sfb_pkg::OP_ACC_STORE);
  assign op_bclr   = live && (st.ir[11:8] == sfb_pkg::OP_BIT_CLEAR);
  assign op_bset   = live && (st.ir[11:8] == sfb_pkg::OP_BIT_SET);
  assign op_tclr   = live && (st.ir[11:8] == sfb_pkg::OP_TEST_CLEAR);
  assign op_tset   = live && (st.ir[11:8] == sfb_pkg::OP_TEST_SET);
  assign to_status = (f_addr == sfb_pkg::STATUS_FILE_ADDR);

  // ==========================================================================
  // Arithmetic
  assign sum_add = {1'b0, st.opnd} + {1'b0, st.w};
  assign sum_sub = {1'b0, st.opnd} + {1'b0, ~st.w} + 9'h001;
  assign nib_add = {1'b0, st.opnd[3:0]} + {1'b0, st.w[3:0]};
  assign nib_sub = {1'b0, st.opnd[3:0]} + {1'b0, ~st.w[3:0]} + 5'h01;

  always_comb begin
    res    = st.opnd;
    upd    = 3'b000;
    c_new  = st.status[sfb_pkg::BIT_C];
    dc_new = st.status[sfb_pkg::BIT_DC];
    if (op_add) begin
      res    = sum_add[7:0];
      upd    = 3'b111;
      c_new  = sum_add[8];
      dc_new = nib_add[4];
    end else if (op_sub) begin
      res    = sum_sub[7:0];
      upd    = 3'b111;
      c_new  = sum_sub[8];
      dc_new = nib_sub[4];
    end else if (op_swap) begin
      res = {st.opnd[3:0], st.opnd[7:4]};
    end else if (op_rrf) begin
      res   = {st.status[sfb_pkg::BIT_C], st.opnd[7:1]};
      upd   = 3'b001;
      c_new = st.opnd[0];
    end else if (op_rlf) begin
      res   = {st.opnd[6:0], st.status[sfb_pkg::BIT_C]};
      upd   = 3'b001;
      c_new = st.opnd[7];
    end else if (op_clr) begin
      res = 8'h00;
      upd = 3'b100;
    end else if (op_store) begin
      res = st.w;
    end else if (op_bset) begin
      res = st.opnd | bit_mask;
    end else if (op_bclr) begin
      res = st.opnd & ~bit_mask;
    end
  end

  assign writes  = op_add || op_sub || op_swap || op_rrf || op_rlf || op_clr ||
                   op_store || op_bset || op_bclr;
  assign to_file = op_clr || op_store || op_bset || op_bclr ||
                   ((op_add || op_sub || op_swap || op_rrf || op_rlf) && dest_f);
  assign to_w    = writes && !to_file;
  assign mem_we  = (st.phase == sfb_pkg::PH_WRITE) && to_file && !to_status;
  assign mem_raddr = instr[4:0];

  // ==========================================================================
  // APB decode
  assign apb_wr  = psel && penable && pwrite;
  assign apb_hit = (paddr == sfb_pkg::ADDR_STATUS) || (paddr == sfb_pkg::ADDR_ACC) ||
                   (paddr == sfb_pkg::ADDR_STATE);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      sfb_pkg::ADDR_STATUS: rd_mux = {24'h00_0000, st.status};
      sfb_pkg::ADDR_ACC:    rd_mux = {24'h00_0000, st.w};
      sfb_pkg::ADDR_STATE:  rd_mux = {27'h000_0000, st.skip_pend, st.phase};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_st           = st;
    next_st.done      = 1'b0;
    next_st.discarded = 1'b0;
    if (psel && !penable) begin
      next_st.prdata = rd_mux;
    end
    // Software writes lose to a same-cycle instruction write back
    if (apb_wr && (paddr == sfb_pkg::ADDR_STATUS)) begin
      next_st.status[7:5] = pwdata[7:5];
      next_st.status[2:0] = pwdata[2:0];
    end
    if (apb_wr && (paddr == sfb_pkg::ADDR_ACC)) begin
      next_st.w = pwdata[7:0];
    end
    case (st.phase)
      sfb_pkg::PH_FETCH: begin
        next_st.phase     = sfb_pkg::PH_READ;
        next_st.ir        = instr;
        next_st.squash    = st.skip_pend || !instr_valid;
        next_st.skip_pend = 1'b0;
        // Idle slots squash too, so remember whether a skip caused it
        next_st.skipped   = st.skip_pend;
      end
      sfb_pkg::PH_READ: begin
        next_st.phase = sfb_pkg::PH_EXEC;
        next_st.opnd  = to_status ? st.status : mem_rdata;
      end
      sfb_pkg::PH_EXEC: begin
        next_st.phase = sfb_pkg::PH_WRITE;
      end
      sfb_pkg::PH_WRITE: begin
        next_st.phase     = sfb_pkg::PH_FETCH;
        next_st.done      = live;
        next_st.discarded = st.squash && st.skipped;
        next_st.skip_pend = (op_tclr && !st.opnd[bit_idx]) ||
                            (op_tset && st.opnd[bit_idx]);
        if (to_w) begin
          next_st.w = res;
        end
        if (to_file && to_status) begin
          next_st.status[7:5] = res[7:5];
          next_st.status[2:0] = (upd != 3'b000) ? st.status[2:0] : res[2:0];
        end
        if (upd[2]) begin
          next_st.status[sfb_pkg::BIT_Z] = (res == 8'h00);
        end
        if (upd[1]) begin
          next_st.status[sfb_pkg::BIT_DC] = dc_new;
        end
        if (upd[0]) begin
          next_st.status[sfb_pkg::BIT_C] = c_new;
        end
      end
      default: begin
        next_st.phase = sfb_pkg::PH_FETCH;
      end
    endcase
    // Reset-cause events; setting wins over a same-cycle clear
    if (wdt_timeout) begin
      next_st.status[sfb_pkg::BIT_TO] = 1'b0;
    end
    if (sleep_exec) begin
      next_st.status[sfb_pkg::BIT_TO] = 1'b1;
      next_st.status[sfb_pkg::BIT_PD] = 1'b0;
    end
    if (wdt_kick) begin
      next_st.status[sfb_pkg::BIT_TO] = 1'b1;
      next_st.status[sfb_pkg::BIT_PD] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata          = st.prdata;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !apb_hit;
  assign instr_ready     = (st.phase == sfb_pkg::PH_FETCH);
  assign instr_done      = st.done;
  assign instr_discarded = st.discarded;
  assign skip_pending    = st.skip_pend;
  assign page_base       = {st.status[sfb_pkg::BIT_PAGE_HI:sfb_pkg::BIT_PAGE_LO],
                            sfb_pkg::PAGE_OFFSET_ZERO};

  // ==========================================================================
  // Checks
  logic in_wr;
  logic no_ev;
  assign in_wr = (st.phase == sfb_pkg::PH_WRITE);
  assign no_ev = !wdt_kick && !sleep_exec && !wdt_timeout;

  property p_cause_ro;
    @(posedge pclk) disable iff (!presetn)
    (apb_wr && (paddr == sfb_pkg::ADDR_STATUS) && no_ev) |=> $stable(st.status[4:3]);
  endproperty
  a_cause_ro: assert property (p_cause_ro) else $error("reset-cause bits took a write");
  property p_clear_status;
    @(posedge pclk) disable iff (!presetn)
    (in_wr && op_clr && to_status) |=>
      (st.status[7:5] == 3'b000) && st.status[2] && $stable(st.status[1:0]);
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("clear on status wrong");
  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
    (wdt_timeout && !wdt_kick && !sleep_exec) |=> !st.status[sfb_pkg::BIT_TO];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout left TO set");
  property p_sleep_pd;
    @(posedge pclk) disable iff (!presetn)
    (sleep_exec && !wdt_kick) |=> !st.status[sfb_pkg::BIT_PD] && st.status[sfb_pkg::BIT_TO];
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("sleep did not clear PD");
  property p_zero;
    @(posedge pclk) disable iff (!presetn)
    (in_wr && op_sub) |=> st.status[sfb_pkg::BIT_Z] == ($past(st.opnd) == $past(st.w));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong after subtract");
  property p_sub_dc;
    @(posedge pclk) disable iff (!presetn)
    (in_wr && op_sub) |=> st.status[sfb_pkg::BIT_DC] == ($past(st.opnd[3:0]) >= $past(st.w[3:0]));
  endproperty
  a_sub_dc: assert property (p_sub_dc) else $error("half-carry wrong after subtract");
  property p_sub_c;
    @(posedge pclk) disable iff (!presetn)
    (in_wr && op_sub) |=> st.status[sfb_pkg::BIT_C] == ($past(st.opnd) >= $past(st.w));
  endproperty
  a_sub_c: assert property (p_sub_c) else $error("carry wrong after subtract");
  property p_bit_set;
    @(posedge pclk) disable iff (!presetn)
    (in_wr && op_bset && !to_status) |-> mem_we && res[bit_idx] && (upd == 3'b000);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set did not set the bit");
  property p_skip_clear;
    @(posedge pclk) disable iff (!presetn)
    (in_wr && op_tclr && !st.opnd[bit_idx]) |-> ##2 st.squash ##3 !st.done;
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("skip on clear bit missed");
  property p_noskip_set;
    @(posedge pclk) disable iff (!presetn)
    (in_wr && op_tset && !st.opnd[bit_idx]) |=> !st.skip_pend;
  endproperty
  a_noskip_set: assert property (p_noskip_set) else $error("test-set skipped on zero");
  property p_swap_w;
    @(posedge pclk) disable iff (!presetn)
    (in_wr && op_swap && !dest_f) |=>
      (st.w == {$past(st.opnd[3:0]), $past(st.opnd[7:4])}) && $stable(st.status[2:0]);
  endproperty
  a_swap_w: assert property (p_swap_w) else $error("swap result wrong");

endmodule

/* verification/sfb_core_tb_top.sv */
// Self-checking testbench of the status flag and bit operation slice
module sfb_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] instr;
  logic        instr_valid;
  logic        instr_ready;
  logic        instr_done;
  logic        instr_discarded;
  logic        skip_pending;
  logic [2:0]  ev;
  logic [10:0] page_base;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          num_checks;
  int          done_cnt;
  int          disc_cnt;
  int          skip_cnt;
  int          d0;

  localparam logic [4:0] SF = sfb_pkg::STATUS_FILE_ADDR;
  localparam logic [7:0] AS = sfb_pkg::ADDR_STATUS;
  localparam logic [7:0] AW = sfb_pkg::ADDR_ACC;

  sfb_core sfb_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_done(instr_done),
    .instr_discarded(instr_discarded), .skip_pending(skip_pending),
    .wdt_kick(ev[0]), .sleep_exec(ev[1]), .wdt_timeout(ev[2]),
    .page_base(page_base)
  );

  // ==========================================================================
  // Clock and completion, discard and skip counters
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (instr_done === 1'b1) begin
      done_cnt <= done_cnt + 1;
    end
    if (instr_discarded === 1'b1) begin
      disc_cnt <= disc_cnt + 1;
    end
    if (skip_pending === 1'b1) begin
      skip_cnt <= skip_cnt + 1;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // No wait bound here: a slave that never answers is cut off by the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rd, exp);
  endtask

  // Phase is only seen at mid-cycle, so land on the edge opening the next slot
  task automatic sync;
    @(negedge pclk);
    while (instr_ready !== 1'b1) @(negedge pclk);
    repeat (4) @(posedge pclk);
  endtask

  task automatic run(input logic [11:0] w);
    instr       <= w;
    instr_valid <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  task automatic exec(input logic [11:0] w);
    sync;
    run(w);
    instr_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic pulse(input int k);
    @(posedge pclk);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev[k] <= 1'b0;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (4000) @(posedge pclk);
    fail_count++;
    summarize;
  end

  // ==========================================================================
  // Tests
  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    instr       = 12'h000;
    instr_valid = 1'b0;
    ev          = 3'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Arithmetic flags reset to zero while TO and PD reset to one, yet they are masked off
    apb(1'b0, AS, 32'h0000_0000);
    chk("status_reset", rd & 32'h0000_00F8, 32'h0000_0018);
    chk("page_reset", {21'h0, page_base}, 32'h0000_0000);
    $display("test reset done");
    apb(1'b1, AS, 32'h0000_0000);
    rchk(AS, 32'h0000_0018, "status_wr");
    apb(1'b1, AS, 32'h0000_0080);
    rchk(AS, 32'h0000_0098, "spare_bit");
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, AS, 32'(p * 32));
      // Page bits update on the access edge, so look once they settle
      @(negedge pclk);
      chk("page_base", {21'h0, page_base}, 32'(p * 512));
      rchk(AS, 32'(p * 32) | 32'h0000_0018, "page_bits");
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
    chk("unmapped_rd", rd, 32'h0000_0000);
    $display("test registers done");
    apb(1'b1, AS, 32'h0000_0000);
    pulse(2);
    rchk(AS, 32'h0000_0008, "timeout");
    pulse(1);
    rchk(AS, 32'h0000_0010, "sleep");
    pulse(0);
    rchk(AS, 32'h0000_0018, "kick");
    $display("test events done");
    apb(1'b1, AS, 32'h0000_0005);
    apb(1'b1, AW, 32'h0000_001D);
    exec({sfb_pkg::OP_SUB, 1'b0, SF});
    rchk(AW, 32'h0000_0000, "sub_zero_w");
    rchk(AS, 32'h0000_001F, "sub_zero_flags");
    apb(1'b1, AS, 32'h0000_0000);
    apb(1'b1, AW, 32'h0000_0019);
    exec({sfb_pkg::OP_SUB, 1'b0, SF});
    rchk(AW, 32'h0000_00FF, "sub_neg_w");
    rchk(AS, 32'h0000_0018, "sub_neg_flags");
    apb(1'b1, AS, 32'h0000_0000);
    apb(1'b1, AW, 32'h0000_0008);
    exec({sfb_pkg::OP_SUB, 1'b1, SF});
    rchk(AS, 32'h0000_001B, "sub_to_status");
    rchk(AW, 32'h0000_0008, "sub_w_kept");
    $display("test subtract done");
    exec({sfb_pkg::OP_SWAP, 1'b0, SF});
    rchk(AW, 32'h0000_00B1, "swap_w");
    rchk(AS, 32'h0000_001B, "swap_flags");
    exec({sfb_pkg::OP_SWAP, 1'b1, SF});
    rchk(AS, 32'h0000_00B9, "swap_status");
    apb(1'b1, AS, 32'h0000_00E1);
    exec({sfb_pkg::OP_CLEAR, SF});
    rchk(AS, 32'h0000_001D, "clear_status");
    $display("test swap and clear done");
    apb(1'b1, AS, 32'h0000_0000);
    apb(1'b1, AW, 32'h0000_00E9);
    exec({sfb_pkg::OP_ADD, 1'b0, SF});
    rchk(AW, 32'h0000_0001, "add_w");
    rchk(AS, 32'h0000_001B, "add_flags");
    apb(1'b1, AS, 32'h0000_0080);
    exec({sfb_pkg::OP_ROT_LEFT, 1'b0, SF});
    rchk(AW, 32'h0000_0030, "rlf_w");
    rchk(AS, 32'h0000_0099, "rlf_flags");
    exec({sfb_pkg::OP_ROT_RIGHT, 1'b0, SF});
    rchk(AW, 32'h0000_00CC, "rrf_w");
    exec({sfb_pkg::OP_ACC_STORE, SF});
    rchk(AS, 32'h0000_00DC, "store_status");
    exec({sfb_pkg::OP_BIT_CLEAR, 3'd7, SF});
    rchk(AS, 32'h0000_005C, "bclr_status");
    $display("test add, rotate and store done");
    // Back-to-back slots: two tests skip, two fall through
    apb(1'b1, AS, 32'h0000_0000);
    d0 = done_cnt;
    sync;
    run({sfb_pkg::OP_TEST_CLEAR, 3'd7, SF});
    run({sfb_pkg::OP_BIT_SET, 3'd6, SF});
    run({sfb_pkg::OP_BIT_SET, 3'd7, SF});
    run({sfb_pkg::OP_TEST_SET, 3'd7, SF});
    run({sfb_pkg::OP_BIT_SET, 3'd5, SF});
    run({sfb_pkg::OP_TEST_CLEAR, 3'd7, SF});
    run({sfb_pkg::OP_BIT_SET, 3'd0, SF});
    run({sfb_pkg::OP_TEST_SET, 3'd6, SF});
    run({sfb_pkg::OP_BIT_SET, 3'd1, SF});
    instr_valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("done_count", 32'(done_cnt - d0), 32'd7);
    chk("discarded", 32'(disc_cnt), 32'd2);
    chk("skip_cycles", 32'(skip_cnt), 32'd2);
    rchk(AS, 32'h0000_009B, "bit_ops");
    $display("test bit ops done");
    summarize;
  end
endmodule
